// file: design/pid_calc_defines.svh
// constants for the incremental pid calculation unit
`ifndef PID_CALC_DEFINES_SVH
`define PID_CALC_DEFINES_SVH

// ************************************************************
// word and datapath widths
// ************************************************************
`define WORD_W        16
`define MAG_W         17
`define DIV_W         40
`define WIDE_W        64

// ************************************************************
// operand layout counts
// ************************************************************
`define GAIN_WORDS    7
`define HIST_WORDS    4
`define RESULT_WORDS  5
`define INPUT_WORDS   2

// ************************************************************
// values
// ************************************************************
`define WORD_ZERO     16'h0000
`define MAG_ZERO      17'h00000
`define MAG_ONE       17'h00001
`define MAG_WORD_MAX  17'h07FFF
`define SAT_HI        16'h7FFF
`define SAT_LO        16'h8000
`define SAT_HI_WIDE   64'h0000_0000_0000_7FFF
`define SAT_LO_WIDE   64'hFFFF_FFFF_FFFF_8000

`endif

// file: design/pid_calc_pkg.sv
// types shared by the incremental pid calculation unit
`include "pid_calc_defines.svh"

package pid_calc_pkg;

  // ************************************************************
  // gain table, seven words in table order
  // ************************************************************
  typedef struct packed {
    logic [`WORD_W-1:0] proportional_gain;
    logic [`WORD_W-1:0] integral_divisor_gain;
    logic [`WORD_W-1:0] integral_multiplier_gain;
    logic [`WORD_W-1:0] derivative_multiplier_gain;
    logic [`WORD_W-1:0] derivative_divisor_gain;
    logic [`WORD_W-1:0] gap;
    logic [`WORD_W-1:0] limit;
  } gain_table_t;

  // ************************************************************
  // history words kept after the output word
  // ************************************************************
  typedef struct packed {
    logic [`WORD_W-1:0] prev_deviation;
    logic [`WORD_W-1:0] prev_input;
    logic [`WORD_W-1:0] prev_prev_input;
    logic [`WORD_W-1:0] integral_remainder;
  } history_t;

  // ************************************************************
  // five result words: increment then history
  // ************************************************************
  typedef struct packed {
    logic [`WORD_W-1:0] increment;
    history_t           history;
  } result_t;

  typedef enum logic {
    ST_IDLE,
    ST_DIVIDE
  } calc_state_t;

endpackage

// file: design/truncating_divider.sv
// iterative signed divider with truncation toward zero
`timescale 1ns/10ps
`include "pid_calc_defines.svh"

module truncating_divider #(
  parameter int NUM_W = `DIV_W,
  parameter int DEN_W = `MAG_W
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    start_i,
  input  wire logic signed [NUM_W-1:0] dividend_i,
  input  wire logic        [DEN_W-1:0] divisor_i,
  output logic signed      [NUM_W-1:0] quotient_o,
  output logic signed      [NUM_W-1:0] remainder_o,
  output logic                         done_o
);
  localparam int CNT_W = $clog2(NUM_W + 1);

  logic [NUM_W-1:0] num_reg;
  logic [DEN_W:0]   rem_reg;
  logic [DEN_W-1:0] den_reg;
  logic [CNT_W-1:0] count_reg;
  logic             neg_reg;
  logic             busy_reg;

  // one quotient bit per cycle keeps the area to a single subtractor
  wire [NUM_W-1:0] num_mag   = dividend_i[NUM_W-1] ? (~dividend_i + 1'b1) : dividend_i;
  wire [DEN_W:0]   rem_shift = {rem_reg[DEN_W-1:0], num_reg[NUM_W-1]};
  wire             fits      = rem_shift >= {1'b0, den_reg};
  wire [DEN_W:0]   rem_step  = fits ? (rem_shift - {1'b0, den_reg}) : rem_shift;
  wire [NUM_W-1:0] q_next    = {num_reg[NUM_W-2:0], fits};
  wire [NUM_W-1:0] r_wide    = {{(NUM_W-DEN_W-1){1'b0}}, rem_step};
  wire             last      = busy_reg && (count_reg == CNT_W'(1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      num_reg     <= '0;
      rem_reg     <= '0;
      den_reg     <= '0;
      count_reg   <= '0;
      neg_reg     <= 1'b0;
      busy_reg    <= 1'b0;
      quotient_o  <= '0;
      remainder_o <= '0;
      done_o      <= 1'b0;
    end else begin
      done_o <= last;
      if (start_i) begin
        num_reg   <= num_mag;
        rem_reg   <= '0;
        den_reg   <= divisor_i;
        count_reg <= CNT_W'(NUM_W);
        neg_reg   <= dividend_i[NUM_W-1];
        busy_reg  <= 1'b1;
      end else if (busy_reg) begin
        num_reg   <= q_next;
        rem_reg   <= rem_step;
        count_reg <= count_reg - 1'b1;
        busy_reg  <= !last;
      end
      if (last) begin
        // quotient truncates toward zero, remainder keeps the dividend sign
        quotient_o  <= neg_reg ? -$signed(q_next) : $signed(q_next);
        remainder_o <= neg_reg ? -$signed(r_wide) : $signed(r_wide);
      end
    end
  end
endmodule

// file: design/deviation_shaper.sv
// limit and gap shaping of the raw deviation
`timescale 1ns/10ps
`include "pid_calc_defines.svh"

module deviation_shaper (
  input  wire logic signed [`MAG_W-1:0]  diff_i,
  input  wire logic        [`WORD_W-1:0] gap_i,
  input  wire logic        [`WORD_W-1:0] limit_i,
  output logic             [`WORD_W-1:0] deviation_o
);
  wire [`MAG_W-1:0] gap_ext  = {gap_i[`WORD_W-1], gap_i};
  wire [`MAG_W-1:0] lim_ext  = {limit_i[`WORD_W-1], limit_i};
  wire [`MAG_W-1:0] diff_mag = diff_i[`MAG_W-1] ? (~diff_i + `MAG_ONE) : diff_i;
  wire [`MAG_W-1:0] gap_mag  = gap_i[`WORD_W-1] ? (~gap_ext + `MAG_ONE) : gap_ext;
  wire [`MAG_W-1:0] lim_raw  = limit_i[`WORD_W-1] ? (~lim_ext + `MAG_ONE) : lim_ext;
  // limit capped at the word maximum so the deviation always fits a word
  wire [`MAG_W-1:0] lim_mag  = (lim_raw > `MAG_WORD_MAX) ? `MAG_WORD_MAX : lim_raw;
  wire [`MAG_W-1:0] clamped  = (diff_mag > lim_mag) ? lim_mag : diff_mag;
  // inside the gap the deviation counts at half weight
  wire [`MAG_W-1:0] shaped   = (clamped <= gap_mag) ? (clamped >> 1) : clamped;
  wire [`MAG_W-1:0] signed_v = diff_i[`MAG_W-1] ? (~shaped + `MAG_ONE) : shaped;

  assign deviation_o = signed_v[`WORD_W-1:0];
endmodule

// file: design/incremental_pid_calculator.sv
// incremental pid calculation unit: top level
`timescale 1ns/10ps
`include "pid_calc_defines.svh"

module incremental_pid_calculator #(
  parameter int DIV_W = `DIV_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      start_i,
  input  wire logic                      enable_i,
  input  wire logic                      error_clear_i,
  input  wire logic [`WORD_W-1:0]        present_value_i,
  input  wire logic [`WORD_W-1:0]        set_value_i,
  input  wire pid_calc_pkg::gain_table_t gains_i,
  input  wire pid_calc_pkg::history_t    history_i,
  output pid_calc_pkg::result_t          result_o,
  output logic                           exec_o,
  output logic                           div_error_o,
  output logic                           done_o,
  output logic                           busy_o
);

  // ************************************************************
  // state and captured operands
  // ************************************************************
  pid_calc_pkg::calc_state_t state_reg;
  pid_calc_pkg::calc_state_t state_next;

  logic [`WORD_W-1:0] dev_reg;
  logic [`WORD_W-1:0] prev_dev_reg;
  logic [`WORD_W-1:0] present_reg;
  logic [`WORD_W-1:0] prev_input_reg;
  logic [`WORD_W-1:0] prop_gain_reg;

  // ************************************************************
  // deviation
  // ************************************************************
  wire signed [`MAG_W-1:0] raw_diff =
    $signed({set_value_i[`WORD_W-1], set_value_i}) -
    $signed({present_value_i[`WORD_W-1], present_value_i});

  // one shaped deviation feeds both the run and the disabled history reload
  wire [`WORD_W-1:0] dev_now;

  deviation_shaper u_shaper (
    .diff_i      (raw_diff),
    .gap_i       (gains_i.gap),
    .limit_i     (gains_i.limit),
    .deviation_o (dev_now)
  );

  // ************************************************************
  // gain magnitudes and divisor check
  // ************************************************************
  // divisor and multiplier gains are used by magnitude, so a negative one acts as its absolute value
  // the most negative word has no positive twin, hence one bit more than a word
  localparam int N_MAG = 4;

  wire [`WORD_W-1:0] gain_word [N_MAG];
  wire [`MAG_W-1:0]  gain_mag  [N_MAG];

  assign gain_word[0] = gains_i.integral_divisor_gain;
  assign gain_word[1] = gains_i.integral_multiplier_gain;
  assign gain_word[2] = gains_i.derivative_multiplier_gain;
  assign gain_word[3] = gains_i.derivative_divisor_gain;

  for (genvar k = 0; k < N_MAG; k++) begin : g_mag
    wire [`MAG_W-1:0] ext = {gain_word[k][`WORD_W-1], gain_word[k]};
    assign gain_mag[k] = ext[`MAG_W-1] ? (~ext + `MAG_ONE) : ext;
  end

  wire [`MAG_W-1:0] int_div_mag = gain_mag[0];
  wire [`MAG_W-1:0] int_mul_mag = gain_mag[1];
  wire [`MAG_W-1:0] der_mul_mag = gain_mag[2];
  wire [`MAG_W-1:0] der_div_mag = gain_mag[3];

  wire divisor_zero = (int_div_mag == `MAG_ZERO) || (der_div_mag == `MAG_ZERO);

  // ************************************************************
  // request decode
  // ************************************************************
  // a request during a run is dropped silently; the caller watches busy
  wire accept      = start_i && (state_reg == pid_calc_pkg::ST_IDLE);
  wire run_off     = accept && !enable_i;
  wire run_error   = accept && enable_i && divisor_zero;
  wire launch      = accept && enable_i && !divisor_zero;

  // ************************************************************
  // dividend operands extended to the divider width: signed words by sign, gain magnitudes by zero
  // ************************************************************
  wire signed [DIV_W-1:0] dev_wide  = DIV_W'($signed(dev_now));
  // the default width holds the largest numerator with room for its sign
  wire signed [DIV_W-1:0] rem_wide  = DIV_W'($signed(history_i.integral_remainder));
  wire signed [DIV_W-1:0] imul_wide = DIV_W'(int_mul_mag);
  wire signed [DIV_W-1:0] dmul_wide = DIV_W'(der_mul_mag);
  wire signed [DIV_W-1:0] p0_wide   = DIV_W'($signed(present_value_i));
  wire signed [DIV_W-1:0] p1_wide   = DIV_W'($signed(history_i.prev_input));
  wire signed [DIV_W-1:0] p2_wide   = DIV_W'($signed(history_i.prev_prev_input));

  // remainder from the last run is carried into this integral step
  wire signed [DIV_W-1:0] int_num   = imul_wide * dev_wide + rem_wide;
  wire signed [DIV_W-1:0] second    = p1_wide + p1_wide - p2_wide - p0_wide;
  wire signed [DIV_W-1:0] der_num   = dmul_wide * second;

  // ************************************************************
  // dividers, both started together so they finish together
  // ************************************************************
  wire signed [DIV_W-1:0] int_quot;
  wire signed [DIV_W-1:0] int_rem;
  wire signed [DIV_W-1:0] der_quot;
  wire                    int_done;
  wire                    der_done;

  truncating_divider #(
    .NUM_W (DIV_W),
    .DEN_W (`MAG_W)
  ) u_int_div (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (launch),
    .dividend_i  (int_num),
    .divisor_i   (int_div_mag),
    .quotient_o  (int_quot),
    .remainder_o (int_rem),
    .done_o      (int_done)
  );

  truncating_divider #(
    .NUM_W (DIV_W),
    .DEN_W (`MAG_W)
  ) u_der_div (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (launch),
    .dividend_i  (der_num),
    .divisor_i   (der_div_mag),
    .quotient_o  (der_quot),
    .remainder_o (),
    .done_o      (der_done)
  );

  // both dividers take the same number of steps, so their done pulses coincide
  wire finish = (state_reg == pid_calc_pkg::ST_DIVIDE) && int_done && der_done;

  // ************************************************************
  // increment and saturation
  // ************************************************************
  wire signed [DIV_W-1:0] dev_cap   = DIV_W'($signed(dev_reg));
  wire signed [DIV_W-1:0] edev_cap  = DIV_W'($signed(prev_dev_reg));
  wire signed [DIV_W-1:0] term_sum  = (dev_cap - edev_cap) + int_quot + der_quot;

  // full-width product, so saturation sees the true value and never a wrapped one
  // the proportional gain is signed: a negative gain reverses the action
  wire signed [`WIDE_W-1:0] sum_wide  = `WIDE_W'(term_sum);
  wire signed [`WIDE_W-1:0] gain_wide = `WIDE_W'($signed(prop_gain_reg));
  wire signed [`WIDE_W-1:0] product   = gain_wide * sum_wide;

  wire over  = product > $signed(`SAT_HI_WIDE);
  wire under = product < $signed(`SAT_LO_WIDE);

  wire [`WORD_W-1:0] inc_sat = over  ? `SAT_HI :
                               under ? `SAT_LO :
                               product[`WORD_W-1:0];

  // ************************************************************
  // result words
  // ************************************************************
  pid_calc_pkg::result_t done_words;
  pid_calc_pkg::result_t off_words;

  always_comb begin
    done_words.increment                  = inc_sat;
    done_words.history.prev_deviation     = dev_reg;
    done_words.history.prev_input         = present_reg;
    done_words.history.prev_prev_input    = prev_input_reg;
    done_words.history.integral_remainder = int_rem[`WORD_W-1:0];
  end

  always_comb begin
    off_words.increment                  = `WORD_ZERO;
    off_words.history.prev_deviation     = dev_now;
    off_words.history.prev_input         = present_value_i;
    off_words.history.prev_prev_input    = present_value_i;
    off_words.history.integral_remainder = `WORD_ZERO;
  end

  // ************************************************************
  // sequencing
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pid_calc_pkg::ST_IDLE: begin
        if (launch) begin
          state_next = pid_calc_pkg::ST_DIVIDE;
        end
      end
      pid_calc_pkg::ST_DIVIDE: begin
        if (finish) begin
          state_next = pid_calc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg      <= pid_calc_pkg::ST_IDLE;
      dev_reg        <= `WORD_ZERO;
      prev_dev_reg   <= `WORD_ZERO;
      present_reg    <= `WORD_ZERO;
      prev_input_reg <= `WORD_ZERO;
      prop_gain_reg  <= `WORD_ZERO;
    end else begin
      state_reg <= state_next;
      if (launch) begin
        // operands may change while dividing, so the ones in use are held
        dev_reg        <= dev_now;
        prev_dev_reg   <= history_i.prev_deviation;
        present_reg    <= present_value_i;
        prev_input_reg <= history_i.prev_input;
        prop_gain_reg  <= gains_i.proportional_gain;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else if (finish) begin
      result_o <= done_words;
    end else if (run_off) begin
      result_o <= off_words;
    end
  end

  // ************************************************************
  // execution output
  // ************************************************************
  // a run refused for a zero divisor leaves the result words untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exec_o <= 1'b0;
    end else if (!enable_i || run_error) begin
      exec_o <= 1'b0;
    end else if (finish) begin
      exec_o <= 1'b1;
    end else if (launch) begin
      exec_o <= 1'b0;
    end
  end

  // ************************************************************
  // division error flag
  // ************************************************************
  // sticky error: a new error in the clearing cycle still wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_error_o <= 1'b0;
    end else if (run_error) begin
      div_error_o <= 1'b1;
    end else if (error_clear_i) begin
      div_error_o <= 1'b0;
    end
  end

  // ************************************************************
  // request handshake
  // ************************************************************
  // done marks every taken request, whatever its outcome
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= finish || run_off || run_error;
      busy_o <= (state_next == pid_calc_pkg::ST_DIVIDE);
    end
  end

endmodule

// file: bench/pid_calc_sva.sv
// assertion checker for the incremental pid calculation unit
`timescale 1ns/10ps
`include "pid_calc_defines.svh"

module pid_calc_sva #(
  parameter int DIV_W = `DIV_W
) (
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      start_i,
  input wire logic                      enable_i,
  input wire logic                      error_clear_i,
  input wire logic [`WORD_W-1:0]        present_value_i,
  input wire logic [`WORD_W-1:0]        set_value_i,
  input wire pid_calc_pkg::gain_table_t gains_i,
  input wire pid_calc_pkg::history_t    history_i,
  input wire pid_calc_pkg::result_t     result_o,
  input wire logic                      exec_o,
  input wire logic                      div_error_o,
  input wire logic                      done_o,
  input wire logic                      busy_o
);
  default clocking main_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ************************************************************
  // request decode
  // ************************************************************
  logic divisors_ok;
  assign divisors_ok = (gains_i.integral_divisor_gain != `WORD_ZERO) &&
                       (gains_i.derivative_divisor_gain != `WORD_ZERO);

  sequence launch_ok_s;
    start_i && !busy_o && enable_i && divisors_ok;
  endsequence
  sequence launch_off_s;
    start_i && !busy_o && !enable_i;
  endsequence
  sequence launch_bad_s;
    start_i && !busy_o && enable_i && !divisors_ok;
  endsequence
  sequence finish_s;
    done_o && !busy_o && exec_o;
  endsequence

  // ************************************************************
  // properties
  // ************************************************************
  chk_run_latency: assert property (launch_ok_s |-> ##42 finish_s)
    else $error("successful run did not finish after 42 cycles");
  chk_busy_span: assert property (launch_ok_s |=> (busy_o && !done_o) [*8])
    else $error("busy dropped early in a run");
  chk_busy_end: assert property (launch_ok_s |-> ##41 busy_o ##1 !busy_o)
    else $error("busy did not end with the result");
  chk_exec_off: assert property (!enable_i |=> !exec_o)
    else $error("execution output high while disabled");
  chk_disabled_load: assert property (launch_off_s |=> done_o && !exec_o &&
      result_o.increment == `WORD_ZERO && result_o.history.integral_remainder == `WORD_ZERO &&
      result_o.history.prev_input == $past(present_value_i) &&
      result_o.history.prev_prev_input == $past(present_value_i))
    else $error("disabled request did not reload history");
  chk_error_flag: assert property (launch_bad_s |=> done_o && div_error_o && !exec_o)
    else $error("zero divisor not flagged");
  chk_error_hold: assert property (launch_bad_s |=> $stable(result_o))
    else $error("zero divisor request changed the result");
  chk_error_sticky: assert property (div_error_o && !error_clear_i |=> div_error_o)
    else $error("division error flag dropped without clear");
  chk_history_shift: assert property (finish_s |->
      result_o.history.prev_input == $past(present_value_i, 42) &&
      result_o.history.prev_prev_input == $past(history_i.prev_input, 42))
    else $error("input history not shifted");
  chk_done_cause: assert property (done_o |-> $past(start_i) || $past(busy_o))
    else $error("done without a request");
endmodule

bind incremental_pid_calculator pid_calc_sva #(.DIV_W(DIV_W)) u_chk (
  .clk_i           (clk_i),
  .rst_i           (rst_i),
  .start_i         (start_i),
  .enable_i        (enable_i),
  .error_clear_i   (error_clear_i),
  .present_value_i (present_value_i),
  .set_value_i     (set_value_i),
  .gains_i         (gains_i),
  .history_i       (history_i),
  .result_o        (result_o),
  .exec_o          (exec_o),
  .div_error_o     (div_error_o),
  .done_o          (done_o),
  .busy_o          (busy_o)
);

// file: bench/incremental_pid_calculator_test.sv
// self-checking testbench for the incremental pid calculation unit
`timescale 1ns/10ps
`include "pid_calc_defines.svh"

module incremental_pid_calculator_test;
  logic                      clk_i;
  logic                      rst_i;
  logic                      start_i;
  logic                      enable_i;
  logic                      error_clear_i;
  logic [`WORD_W-1:0]        present_value_i;
  logic [`WORD_W-1:0]        set_value_i;
  pid_calc_pkg::gain_table_t gains_i;
  pid_calc_pkg::history_t    history_i;
  pid_calc_pkg::result_t     result_o;
  logic                      exec_o;
  logic                      div_error_o;
  logic                      done_o;
  logic                      busy_o;
  int                        n_mismatch;
  int                        samples_checked;

  typedef struct {
    pid_calc_pkg::gain_table_t g;
    pid_calc_pkg::history_t    h;
    logic [`WORD_W-1:0]        pv;
    logic [`WORD_W-1:0]        sv;
    pid_calc_pkg::result_t     r;
  } row_t;
  row_t rows[6];

  localparam pid_calc_pkg::gain_table_t G_EX =
    {16'h0001, 16'h0004, 16'h000A, 16'h0014, 16'h0005, 16'h0000, 16'h0064};
  localparam pid_calc_pkg::history_t H_EX = {16'h004E, 16'h0016, 16'h0014, 16'h0000};
  localparam pid_calc_pkg::result_t R_EX =
    {16'h00B4, 16'h004B, 16'h0019, 16'h0016, 16'h0002};
  localparam pid_calc_pkg::result_t R_DIS =
    {16'h0000, 16'h004B, 16'h0019, 16'h0019, 16'h0000};

  incremental_pid_calculator DUT (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .start_i         (start_i),
    .enable_i        (enable_i),
    .error_clear_i   (error_clear_i),
    .present_value_i (present_value_i),
    .set_value_i     (set_value_i),
    .gains_i         (gains_i),
    .history_i       (history_i),
    .result_o        (result_o),
    .exec_o          (exec_o),
    .div_error_o     (div_error_o),
    .done_o          (done_o),
    .busy_o          (busy_o)
  );

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // inputs change on the falling edge so the design samples settled values
  task automatic launch(input pid_calc_pkg::gain_table_t g, input pid_calc_pkg::history_t h,
                        input logic [15:0] pv, input logic [15:0] sv, input logic en);
    @(negedge clk_i);
    gains_i = g;
    history_i = h;
    present_value_i = pv;
    set_value_i = sv;
    enable_i = en;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
  endtask

  // bounded wait: a hung divider counts as a mismatch and ends the simulation instead of hanging it
  task automatic wait_done(output int n);
    n = 1;
    while (done_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 100) begin
      n_mismatch++;
      close_out();
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int n;
    pid_calc_pkg::gain_table_t g;
    rst_i = 1'b1;
    start_i = 1'b0;
    enable_i = 1'b0;
    error_clear_i = 1'b0;
    present_value_i = `WORD_ZERO;
    set_value_i = `WORD_ZERO;
    gains_i = '0;
    history_i = '0;
    n_mismatch = 0;
    samples_checked = 0;
    rows[0] = '{G_EX, H_EX, 16'h0019, 16'h0064, R_EX};
    rows[1] = rows[0];
    rows[1].g.proportional_gain = 16'h00C8;
    rows[1].r.increment = `SAT_HI;
    rows[2] = rows[0];
    rows[2].g.proportional_gain = 16'hFF38;
    rows[2].r.increment = `SAT_LO;
    rows[3] = '{G_EX, {16'h0000, 16'h0064, 16'h0064, 16'h0000}, 16'h0064, 16'h0019,
                {16'hFEFA, 16'hFFB5, 16'h0064, 16'h0064, 16'hFFFE}};
    rows[4] = '{{16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0001, 16'h000A, 16'h0064},
                '0, 16'h0000, 16'h0008, {16'h0008, 16'h0004, 16'h0000, 16'h0000, 16'h0000}};
    rows[5] = '{{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0064},
                '0, 16'h0000, 16'h03E8, {16'h0064, 16'h0064, 16'h0000, 16'h0000, 16'h0000}};
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    check(result_o, 80'h0);
    check(80'({exec_o, div_error_o, done_o, busy_o}), 80'h0);

    for (int i = 0; i < 6; i++) begin
      launch(rows[i].g, rows[i].h, rows[i].pv, rows[i].sv, 1'b1);
      wait_done(n);
      check(80'(n), 80'(42));
      check(result_o, rows[i].r);
      check(80'(exec_o), 80'h1);
    end

    // exec falls with enable even with no new request
    @(negedge clk_i);
    enable_i = 1'b0;
    @(negedge clk_i);
    check(80'(exec_o), 80'h0);

    launch(G_EX, H_EX, 16'h0019, 16'h0064, 1'b0);
    wait_done(n);
    check(80'(n), 80'h1);
    check(result_o, R_DIS);

    // each zero divisor alone refuses the run and leaves the result alone
    for (int j = 0; j < 2; j++) begin
      g = G_EX;
      if (j == 0) begin
        g.integral_divisor_gain = `WORD_ZERO;
      end else begin
        g.derivative_divisor_gain = `WORD_ZERO;
      end
      launch(g, H_EX, 16'h0019, 16'h0064, 1'b1);
      wait_done(n);
      check(80'(n), 80'h1);
      check(80'({exec_o, div_error_o}), 80'h1);
      check(result_o, R_DIS);
      @(negedge clk_i);
      error_clear_i = 1'b1;
      @(negedge clk_i);
      error_clear_i = 1'b0;
      check(80'(div_error_o), 80'h0);
    end

    // a bad request while busy must be ignored, not flagged
    launch(G_EX, H_EX, 16'h0019, 16'h0064, 1'b1);
    repeat (3) @(negedge clk_i);
    gains_i = g;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    gains_i = G_EX;
    wait_done(n);
    check(80'(n), 80'(38));
    check(result_o, R_EX);
    check(80'({exec_o, div_error_o}), 80'h2);
    close_out();
  end
endmodule
